// >>> shared/cip_pkg.sv
// Shared types and constants for the current-input channel processing block
package cip_pkg;

  localparam int NUM_CH = 16;
  localparam int ADDR_W = 10;
  localparam int FRAC_W = 8;

  // Measurement type codes
  localparam logic [1:0] MT_DISABLED = 2'h0;
  localparam logic [1:0] MT_TWO_WIRE = 2'h1;
  localparam logic [1:0] MT_FOUR_WIRE = 2'h2;

  // Measuring range codes
  localparam logic [1:0] RNG_BIP20 = 2'h0;
  localparam logic [1:0] RNG_0_20 = 2'h1;
  localparam logic [1:0] RNG_4_20 = 2'h2;

  // Mains suppression codes
  localparam logic [1:0] SUP_400HZ = 2'h0;
  localparam logic [1:0] SUP_60HZ = 2'h1;
  localparam logic [1:0] SUP_50HZ = 2'h2;
  localparam logic [1:0] SUP_10HZ = 2'h3;

  // Smoothing levels and their shift (k = 1, 4, 16, 32)
  localparam logic [1:0] SM_NONE = 2'h0;
  localparam logic [1:0] SM_WEAK = 2'h1;
  localparam logic [1:0] SM_MEDIUM = 2'h2;
  localparam logic [1:0] SM_STRONG = 2'h3;
  localparam logic [2:0] SH_NONE = 3'h0;
  localparam logic [2:0] SH_WEAK = 3'h2;
  localparam logic [2:0] SH_MEDIUM = 3'h4;
  localparam logic [2:0] SH_STRONG = 3'h5;

  // Diagnostic bit positions
  localparam int DG_OVF = 0;
  localparam int DG_UDF = 1;
  localparam int DG_CM = 2;
  localparam int DG_WB = 3;

  // Limit bit positions: low 1, high 1, low 2, high 2
  localparam int LM_LO1 = 0;
  localparam int LM_HI1 = 1;
  localparam int LM_LO2 = 2;
  localparam int LM_HI2 = 3;

  // Range ends, wire-break floor and limit reset values in output counts
  localparam logic signed [15:0] VAL_RANGE_HI = 16'sh6C00;
  localparam logic signed [15:0] VAL_RANGE_LO_BIP = 16'sh9400;
  localparam logic signed [15:0] VAL_RANGE_LO_UNI = 16'sh0000;
  localparam logic signed [15:0] VAL_WB_FLOOR = 16'shED00;
  localparam logic signed [15:0] LIM_LO_RST = 16'sh8000;
  localparam logic signed [15:0] LIM_HI_RST = 16'sh7FFF;

  // Per-channel register indexes (byte address = {0, chan, index, 00})
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_LO1 = 3'h1;
  localparam logic [2:0] REG_HI1 = 3'h2;
  localparam logic [2:0] REG_LO2 = 3'h3;
  localparam logic [2:0] REG_HI2 = 3'h4;
  localparam logic [2:0] REG_VAL = 3'h5;
  localparam logic [2:0] REG_STAT = 3'h6;

  // Global registers
  localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 10'h200;
  localparam logic [ADDR_W-1:0] ADR_IRQ_CLR = 10'h204;
  localparam logic [ADDR_W-1:0] ADR_IRQ_EN = 10'h208;
  localparam logic [ADDR_W-1:0] ADR_CYC_CNT = 10'h20C;

  typedef struct packed {
    logic [3:0] hw_int_en;
    logic [3:0] diag_en;
    logic [1:0] smooth;
    logic [1:0] supp;
    logic [1:0] range;
    logic [1:0] mtype;
  } cip_cfg_t;

  localparam cip_cfg_t CFG_RST = '{hw_int_en: 4'h0, diag_en: 4'h0, smooth: SM_NONE,
                                   supp: SUP_50HZ, range: RNG_BIP20, mtype: MT_FOUR_WIRE};

  typedef struct packed {
    logic [3:0] chan;
    logic signed [15:0] data;
    logic cm_err;
    logic no_current;
  } cip_sample_t;

endpackage

// >>> rtl/cip_top.sv
// Current-input channel processing: sequencing, smoothing, diagnostics, limits
//
// Function
// - After reset each channel is four-wire type, bipolar 20 mA range.
// - Disabled channels are skipped; they raise no interrupts or diagnostics.
// - Wire break is reported only in the 4 to 20 mA range.
// - Overflow enabled: report when measured value exceeds the range top.
// - Underflow enabled: report when measured value falls below the range bottom.
// - Common-mode enabled: report when the front end flags common-mode excess.
// - Wire break enabled: report on no current or current too small.
// - Smoothing levels none, weak, medium, strong use k of 1, 4, 16, 32.
// - Smoothing time is k times the module cycle time.
// - After a step the output covers about two thirds of it within k module cycles (all of it for k = 1).
// - Suppression selectable 400, 60, 50 or 10 Hz, default 50 Hz.
// - Four separate limit interrupt enables per channel gate each interrupt.
// - Two low limits per channel trigger their interrupt when violated.
// - Two high limits per channel trigger their interrupt when violated.
// - Conversion integrates over the configured mains suppression period.
// - Values are 16-bit signed; each of sixteen channels has own limits.
`timescale 1ns/1ps
`default_nettype none

module cip_top
  import cip_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic smp_valid,
  input wire cip_sample_t smp,
  output logic conv_req,
  output logic [3:0] conv_chan,
  output logic [1:0] conv_supp,
  output logic val_valid,
  output logic [3:0] val_chan,
  output logic signed [15:0] val_data,
  output logic cycle_done,
  output logic irq
);

  localparam int ACC_W = 16 + FRAC_W;

  ////////////////////////////////////////////////////////////////////////////
  // State
  cip_cfg_t cfg_r [NUM_CH];
  logic signed [15:0] lim_r [NUM_CH][4];
  logic signed [ACC_W-1:0] acc_r [NUM_CH];
  logic [3:0] diag_r [NUM_CH];
  logic [3:0] lim_hit_r [NUM_CH];
  logic [31:0] irq_stat_r;
  logic [31:0] irq_en_r;
  logic [15:0] cyc_cnt_r;
  logic [3:0] scan_ch_r;
  logic [31:0] rdata_r;
  logic conv_req_r;
  logic [3:0] conv_chan_r;
  logic [1:0] conv_supp_r;
  logic val_valid_r;
  logic [3:0] val_chan_r;
  logic signed [15:0] val_data_r;
  logic cycle_done_r;
  logic irq_r;

  typedef enum logic {SQ_SCAN, SQ_WAIT} cip_sq_t;
  cip_sq_t sq_st_r;

  assign rdata = rdata_r;
  assign conv_req = conv_req_r;
  assign conv_chan = conv_chan_r;
  assign conv_supp = conv_supp_r;
  assign val_valid = val_valid_r;
  assign val_chan = val_chan_r;
  assign val_data = val_data_r;
  assign cycle_done = cycle_done_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic ch_sel;
  logic [3:0] bus_ch;
  logic [2:0] bus_reg;
  logic [31:0] irq_clr;
  assign ch_sel = (addr[9] == 1'b0);
  assign bus_ch = addr[8:5];
  assign bus_reg = addr[4:2];
  assign irq_clr = (wr && addr == ADR_IRQ_CLR) ? wdata : 32'h0000_0000;

  // Settings are taken at any time, also while conversions run
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        cfg_r[i] <= CFG_RST;
        lim_r[i][LM_LO1] <= LIM_LO_RST;
        lim_r[i][LM_HI1] <= LIM_HI_RST;
        lim_r[i][LM_LO2] <= LIM_LO_RST;
        lim_r[i][LM_HI2] <= LIM_HI_RST;
      end
      irq_en_r <= 32'h0000_0000;
    end
    else if (wr)
    begin
      if (ch_sel && bus_reg == REG_CFG)
        cfg_r[bus_ch] <= cip_cfg_t'(wdata[15:0]);
      else if (ch_sel && bus_reg >= REG_LO1 && bus_reg <= REG_HI2)
        lim_r[bus_ch][2'(bus_reg - REG_LO1)] <= wdata[15:0];
      else if (addr == ADR_IRQ_EN)
        irq_en_r <= wdata;
    end
  end

  // Read data stand in the cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_r <= 32'h0000_0000;
    else if (!rd)
      rdata_r <= 32'h0000_0000;
    else if (ch_sel)
    begin
      case (bus_reg)
        REG_CFG: rdata_r <= {16'h0000, cfg_r[bus_ch]};
        REG_LO1, REG_HI1, REG_LO2, REG_HI2:
          rdata_r <= {{16{lim_r[bus_ch][2'(bus_reg - REG_LO1)][15]}}, lim_r[bus_ch][2'(bus_reg - REG_LO1)]};
        REG_VAL: rdata_r <= {{16{acc_r[bus_ch][ACC_W-1]}}, acc_r[bus_ch][ACC_W-1:FRAC_W]};
        REG_STAT: rdata_r <= (cfg_r[bus_ch].mtype == MT_DISABLED) ? 32'h0000_0000 :
                             {24'h00_0000, lim_hit_r[bus_ch], diag_r[bus_ch]};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
    else if (addr == ADR_IRQ_STAT)
      rdata_r <= irq_stat_r;
    else if (addr == ADR_IRQ_EN)
      rdata_r <= irq_en_r;
    else if (addr == ADR_CYC_CNT)
      rdata_r <= {16'h0000, cyc_cnt_r};
    else
      rdata_r <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: one module cycle visits every enabled channel
  logic take;
  logic sq_en_ok;
  assign sq_en_ok = (cfg_r[scan_ch_r].mtype != MT_DISABLED);
  assign take = (sq_st_r == SQ_WAIT) && smp_valid && (smp.chan == conv_chan_r) &&
                (cfg_r[conv_chan_r].mtype != MT_DISABLED);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sq_st_r <= SQ_SCAN;
      scan_ch_r <= 4'h0;
      conv_req_r <= 1'b0;
      conv_chan_r <= 4'h0;
      conv_supp_r <= SUP_50HZ;
      cycle_done_r <= 1'b0;
      cyc_cnt_r <= 16'h0000;
    end
    else
    begin
      conv_req_r <= 1'b0;
      cycle_done_r <= 1'b0;
      case (sq_st_r)
        SQ_SCAN:
        begin
          if (sq_en_ok)
          begin
            conv_req_r <= 1'b1;
            conv_chan_r <= scan_ch_r;
            conv_supp_r <= cfg_r[scan_ch_r].supp;
            sq_st_r <= SQ_WAIT;
          end
          else
          begin
            // Disabled channel costs one idle cycle, no conversion
            scan_ch_r <= scan_ch_r + 4'h1;
            if (scan_ch_r == 4'hF)
            begin
              cycle_done_r <= 1'b1;
              cyc_cnt_r <= cyc_cnt_r + 16'h0001;
            end
          end
        end
        SQ_WAIT:
        begin
          // A channel disabled mid-conversion drops its sample
          if (smp_valid && smp.chan == conv_chan_r)
          begin
            scan_ch_r <= scan_ch_r + 4'h1;
            sq_st_r <= SQ_SCAN;
            if (scan_ch_r == 4'hF)
            begin
              cycle_done_r <= 1'b1;
              cyc_cnt_r <= cyc_cnt_r + 16'h0001;
            end
          end
        end
        default: sq_st_r <= SQ_SCAN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Smoothing, diagnostics and limit checks for the arriving sample
  cip_cfg_t c;
  logic signed [15:0] x;
  logic [2:0] shift;
  logic signed [ACC_W:0] diff;
  logic signed [ACC_W-1:0] acc_nxt;
  logic signed [15:0] filt;
  logic signed [15:0] rng_lo;
  logic [3:0] diag_nxt;
  logic [3:0] lim_nxt;

  always_comb
  begin
    c = cfg_r[conv_chan_r];
    x = smp.data;
    case (c.smooth)
      SM_NONE: shift = SH_NONE;
      SM_WEAK: shift = SH_WEAK;
      SM_MEDIUM: shift = SH_MEDIUM;
      default: shift = SH_STRONG;
    endcase
    // Weight 1/k per module cycle gives a time constant of about k cycles
    diff = {x[15], x, {FRAC_W{1'b0}}} - {acc_r[conv_chan_r][ACC_W-1], acc_r[conv_chan_r]};
    acc_nxt = acc_r[conv_chan_r] + (ACC_W)'(diff >>> shift);
    filt = acc_nxt[ACC_W-1:FRAC_W];
    rng_lo = (c.range == RNG_BIP20) ? VAL_RANGE_LO_BIP : VAL_RANGE_LO_UNI;
    diag_nxt[DG_OVF] = c.diag_en[DG_OVF] && (x > VAL_RANGE_HI);
    diag_nxt[DG_UDF] = c.diag_en[DG_UDF] && (x < rng_lo);
    diag_nxt[DG_CM] = c.diag_en[DG_CM] && smp.cm_err;
    diag_nxt[DG_WB] = c.diag_en[DG_WB] && (c.range == RNG_4_20) &&
                      (smp.no_current || x < VAL_WB_FLOOR);
    for (int k = 0; k < 4; k++)
    begin
      if (k[0] == 1'b0)
        lim_nxt[k] = c.hw_int_en[k] && (filt < lim_r[conv_chan_r][k]);
      else
        lim_nxt[k] = c.hw_int_en[k] && (filt > lim_r[conv_chan_r][k]);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        acc_r[i] <= '0;
        diag_r[i] <= 4'h0;
        lim_hit_r[i] <= 4'h0;
      end
    end
    else if (take)
    begin
      acc_r[conv_chan_r] <= acc_nxt;
      diag_r[conv_chan_r] <= diag_nxt;
      lim_hit_r[conv_chan_r] <= lim_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      val_valid_r <= 1'b0;
      val_chan_r <= 4'h0;
      val_data_r <= 16'sh0000;
    end
    else
    begin
      val_valid_r <= take;
      if (take)
      begin
        val_chan_r <= conv_chan_r;
        val_data_r <= filt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: [15:0] limit events, [31:16] diagnostic events per channel
  logic [31:0] irq_set;
  always_comb
  begin
    irq_set = 32'h0000_0000;
    if (take)
    begin
      irq_set[conv_chan_r] = |lim_nxt;
      irq_set[16 + 32'(conv_chan_r)] = |diag_nxt;
    end
  end

  // A set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_stat_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq_r <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [3:0] chk_ch;
  assign chk_ch = val_chan_r;

  chk_default_cfg: assert property (@(posedge mclk) $past(rst) && !rst |->
    cfg_r[0].mtype == MT_FOUR_WIRE && cfg_r[15].range == RNG_BIP20 && cfg_r[7].supp == SUP_50HZ)
    else $error("channel defaults wrong after reset");

  chk_skip_disabled: assert property (@(posedge mclk) disable iff (rst)
    conv_req_r |-> $past(sq_en_ok) && $past(sq_st_r) == SQ_SCAN)
    else $error("conversion issued for disabled channel");

  chk_wb_range: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r && diag_r[chk_ch][DG_WB] |-> $past(c.range) == RNG_4_20)
    else $error("wire break outside 4-20 range");

  chk_ovf_flag: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r |-> diag_r[chk_ch][DG_OVF] == ($past(c.diag_en[DG_OVF]) && $past(x) > VAL_RANGE_HI))
    else $error("overflow flag mismatch");

  chk_udf_flag: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r |-> diag_r[chk_ch][DG_UDF] == ($past(c.diag_en[DG_UDF]) && $past(x) < $past(rng_lo)))
    else $error("underflow flag mismatch");

  chk_cm_flag: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r |-> diag_r[chk_ch][DG_CM] == ($past(c.diag_en[DG_CM]) && $past(smp.cm_err)))
    else $error("common-mode flag mismatch");

  chk_wb_flag: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r && $past(c.range) == RNG_4_20 && $past(c.diag_en[DG_WB]) && $past(smp.no_current)
    |-> diag_r[chk_ch][DG_WB])
    else $error("wire break not raised");

  // The level lags the enable by one edge, as the output is registered
  chk_irq_level: assert property (@(posedge mclk) disable iff (rst)
    irq_r == |(irq_stat_r & $past(irq_en_r)))
    else $error("interrupt level disagrees with status");

  chk_smooth_none: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r && $past(c.smooth) == SM_NONE |-> val_data_r == $past(x))
    else $error("unsmoothed value differs from sample");

  chk_lim_enable: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r |-> (lim_hit_r[chk_ch] & ~$past(c.hw_int_en)) == 4'h0)
    else $error("limit hit without its enable");

  chk_low_limit: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r && $past(c.hw_int_en[LM_LO2]) && val_data_r < $past(lim_r[conv_chan_r][LM_LO2])
    |-> lim_hit_r[chk_ch][LM_LO2] && irq_stat_r[chk_ch])
    else $error("low limit 2 violation not raised");

  chk_high_limit: assert property (@(posedge mclk) disable iff (rst)
    val_valid_r && $past(c.hw_int_en[LM_HI1]) && val_data_r > $past(lim_r[conv_chan_r][LM_HI1])
    |-> lim_hit_r[chk_ch][LM_HI1] ##1 irq_stat_r[chk_ch] || $past(irq_clr[chk_ch]))
    else $error("high limit 1 violation not raised");

  chk_supp_issue: assert property (@(posedge mclk) disable iff (rst)
    $rose(conv_req_r) |-> conv_supp_r == $past(cfg_r[scan_ch_r].supp))
    else $error("suppression setting not forwarded");

endmodule

`default_nettype wire

// >>> sim/cip_fe_model.sv
// Front-end model: answers each conversion request with one sample
`timescale 1ns/1ps
`default_nettype none

module cip_fe_model
  import cip_pkg::*;
#(
  parameter int DLY = 3
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic conv_req,
  input wire logic [3:0] conv_chan,
  input wire logic [1:0] conv_supp,
  output logic smp_valid,
  output cip_sample_t smp
);
  logic signed [15:0] lvl [NUM_CH];
  logic cm [NUM_CH];
  logic nc [NUM_CH];
  logic [1:0] supp_seen [NUM_CH];
  logic [3:0] ch_r;
  int cnt;
  logic fire;

  assign fire = !rst && !conv_req && cnt == 1;

  initial
  begin
    smp_valid = 1'b0;
    smp = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      lvl[i] = 16'sh0000;
      cm[i] = 1'b0;
      nc[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data lines toggle between samples so a stale word never looks fresh
  // Each signal is assigned once per edge so the strobe never glitches
  always @(posedge mclk)
  begin
    smp_valid <= fire;
    smp <= fire ? cip_sample_t'{chan: ch_r, data: lvl[ch_r], cm_err: cm[ch_r], no_current: nc[ch_r]} :
                  cip_sample_t'(~smp);
    if (rst)
    begin
      cnt <= 0;
      ch_r <= 4'h0;
    end
    else if (conv_req)
    begin
      cnt <= DLY;
      ch_r <= conv_chan;
      supp_seen[conv_chan] <= conv_supp;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the channel processing block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import cip_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic smp_valid;
  cip_sample_t smp;
  logic conv_req;
  logic [3:0] conv_chan;
  logic [1:0] conv_supp;
  logic val_valid;
  logic [3:0] val_chan;
  logic signed [15:0] val_data;
  logic cycle_done;
  logic irq;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] q;
  logic [15:0] v;
  logic [15:0] e1;
  logic [15:0] e2;
  int sh;
  logic seen_dis = 1'b0;
  // Diagnostic cases: config, level, common mode, no current, expected flags
  logic [15:0] dcfg [8] = '{16'h0102, 16'h0202, 16'h0402, 16'h080A, 16'h0809, 16'h0802, 16'h0002, 16'h0206};
  logic [15:0] dlvl [8] = '{16'h7000, 16'h9000, 16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h7000, 16'hF000};
  logic [7:0] dcm = 8'b0000_0100;
  logic [7:0] dnc = 8'b0011_1000;
  logic [3:0] dexp [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h0, 4'h0, 4'h2};

  always #25 mclk = ~mclk;

  cip_top dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .smp_valid(smp_valid), .smp(smp), .conv_req(conv_req), .conv_chan(conv_chan), .conv_supp(conv_supp),
    .val_valid(val_valid), .val_chan(val_chan), .val_data(val_data), .cycle_done(cycle_done), .irq(irq));

  cip_fe_model fe_u (.mclk(mclk), .rst(rst), .conv_req(conv_req), .conv_chan(conv_chan),
    .conv_supp(conv_supp), .smp_valid(smp_valid), .smp(smp));

  always @(posedge mclk)
  begin
    if (conv_req === 1'b1 && conv_chan === 4'h4)
      seen_dis <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [ADDR_W-1:0] ra(input int n, input logic [2:0] r);
    return ADDR_W'(n * 32 + int'(r) * 4);
  endfunction

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Kind 0 waits for a value of channel ch, kind 1 for the end of a module cycle
  task automatic wait_ev(input int kind, input int ch, output logic [15:0] d);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge mclk);
      #1;
      if (kind == 1 ? cycle_done === 1'b1 : (val_valid === 1'b1 && val_chan === 4'(ch)))
        break;
    end
    d = val_data;
    if (i == 3000)
    begin
      error_cnt++;
      $display("BAD event wait expected kind %0d seen none", kind);
      tally_and_finish();
    end
  endtask

  // Two values so a conversion already in flight has drained
  task automatic settle(input int ch);
    logic [15:0] t;
    wait_ev(0, ch, t);
    wait_ev(0, ch, t);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(ra(0, REG_CFG), q);
    chk("cfg default", 32'h0000_0022, q);
    rd_reg(ra(7, REG_LO1), q);
    chk("low limit default", 32'hFFFF_8000, q);
    rd_reg(ra(7, REG_HI2), q);
    chk("high limit default", 32'h0000_7FFF, q);
    rd_reg(10'h3F0, q);
    chk("unmapped read", 32'h0000_0000, q);
    $display("test defaults done");

    for (int s = 0; s < 4; s++)
    begin
      sh = (s == 0) ? 0 : (s == 1) ? 2 : (s == 2) ? 4 : 5;
      fe_u.lvl[5] = 16'sh0000;
      wr_reg(ra(5, REG_CFG), 32'h0000_0022);
      settle(5);
      fe_u.lvl[5] = 16'sh2000;
      wr_reg(ra(5, REG_CFG), 32'(s * 64 + 32'h22));
      e1 = 16'h2000 >> sh;
      e2 = e1 + ((16'h2000 - e1) >> sh);
      wait_ev(0, 5, v);
      chk("first smoothed", {16'h0000, e1}, {16'h0000, v});
      wait_ev(0, 5, v);
      chk("second smoothed", {16'h0000, e2}, {16'h0000, v});
      rd_reg(ra(5, REG_VAL), q);
      chk("value register", {16'h0000, e2}, q);
    end
    $display("test smoothing done");

    for (int c = 0; c < 4; c++)
    begin
      wr_reg(ra(1, REG_CFG), 32'(c * 16 + 2));
      settle(1);
      chk("suppression code", 32'(c), {30'h0, fe_u.supp_seen[1]});
      rd_reg(ra(1, REG_CFG), q);
      chk("cfg readback", 32'(c * 16 + 2), q);
    end
    $display("test suppression done");

    for (int i = 0; i < 8; i++)
    begin
      fe_u.lvl[2] = dlvl[i];
      fe_u.cm[2] = dcm[i];
      fe_u.nc[2] = dnc[i];
      wr_reg(ra(2, REG_CFG), {16'h0000, dcfg[i]});
      settle(2);
      rd_reg(ra(2, REG_STAT), q);
      chk("diag flags", {28'h0, dexp[i]}, q & 32'h0000_000F);
    end
    rd_reg(ADR_IRQ_STAT, q);
    chk("diag event", 32'h0004_0000, q & 32'h0004_0000);
    $display("test diagnostics done");

    fe_u.lvl[3] = 16'sh0000;
    fe_u.lvl[6] = 16'sh1000;
    fe_u.lvl[8] = 16'sh1000;
    wr_reg(ra(3, REG_LO1), 32'h0000_0100);
    wr_reg(ra(3, REG_LO2), 32'h0000_0100);
    wr_reg(ra(3, REG_CFG), 32'h0000_5002);
    wr_reg(ra(6, REG_HI2), 32'h0000_0010);
    wr_reg(ra(6, REG_HI1), 32'h0000_0010);
    wr_reg(ra(6, REG_CFG), 32'h0000_A002);
    wr_reg(ra(8, REG_HI1), 32'h0000_0010);
    wr_reg(ra(8, REG_CFG), 32'h0000_0002);
    settle(3);
    settle(6);
    settle(8);
    rd_reg(ra(3, REG_STAT), q);
    chk("limit hit", 32'h0000_0050, q);
    rd_reg(ra(6, REG_STAT), q);
    chk("high limit hit", 32'h0000_00A0, q);
    rd_reg(ra(8, REG_STAT), q);
    chk("limit without enable", 32'h0000_0000, q);
    rd_reg(ADR_IRQ_STAT, q);
    chk("limit events", 32'h0000_0048, q & 32'h0000_0148);
    wr_reg(ADR_IRQ_EN, 32'h0000_0008);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr_reg(ADR_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    fe_u.lvl[3] = 16'sh0200;
    settle(3);
    wr_reg(ADR_IRQ_EN, 32'h0000_0008);
    wr_reg(ADR_IRQ_CLR, 32'h0000_0008);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd_reg(ADR_IRQ_CLR, q);
    chk("clear reads zero", 32'h0, q);
    $display("test limits done");

    wr_reg(ra(4, REG_CFG), 32'h0000_0000);
    wait_ev(1, 0, v);
    seen_dis = 1'b0;
    rd_reg(ADR_CYC_CNT, q);
    e1 = q[15:0];
    wait_ev(1, 0, v);
    chk("disabled skipped", 32'h0, {31'h0, seen_dis});
    rd_reg(ADR_CYC_CNT, q);
    chk("cycle count", {16'h0000, e1 + 16'h0001}, q);
    rd_reg(ra(4, REG_STAT), q);
    chk("disabled status", 32'h0, q);
    $display("test disabled done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
